// *** hdl/irsl_pkg.sv ***
// Shared constants and carrier types for the infrared secondary link setup block
package irsl_pkg;

    // ****************************************
    // Timing
    // ****************************************
    localparam int unsigned CLK_HZ    = 50_000_000;
    localparam int unsigned BAUD_RATE = 9600;
    localparam int unsigned BAUD_DIV  = CLK_HZ / BAUD_RATE;
    localparam int unsigned BAUD_W    = 13;

    // ****************************************
    // Negotiation parameters sent in the UA reply to SNRM; the UA reply to DISC carries zeros
    // ****************************************
    localparam logic [7:0] RATE_CODE_9600  = 8'h02;
    localparam logic [7:0] TURNAROUND_CODE = 8'h01;
    localparam logic [7:0] WINDOW_CODE     = 8'h01;
    localparam logic [7:0] DISC_WAIT_CODE  = 8'h01;

    // ****************************************
    // Frame kinds and slot numbers
    // ****************************************
    typedef enum logic [2:0] {
        IRSL_RX_OTHER = 3'b000,
        IRSL_RX_XID   = 3'b001,
        IRSL_RX_BCAST = 3'b010,
        IRSL_RX_SNRM  = 3'b011,
        IRSL_RX_DISC  = 3'b100
    } irsl_rx_kind_t;

    typedef enum logic [1:0] {
        IRSL_TX_NONE    = 2'b00,
        IRSL_TX_XID_RSP = 2'b01,
        IRSL_TX_UA      = 2'b10
    } irsl_tx_kind_t;

    localparam logic [7:0] OWN_SLOT = 8'h00;

    // ****************************************
    // Link states
    // ****************************************
    typedef enum logic [1:0] {
        IRSL_ST_NDM   = 2'b00,
        IRSL_ST_CLAIM = 2'b01,
        IRSL_ST_DISCV = 2'b10,
        IRSL_ST_CONN  = 2'b11
    } irsl_state_t;

    // ****************************************
    // Carriers
    // ****************************************
    typedef struct packed {
        irsl_rx_kind_t kind;
        logic [7:0]    slot;
    } irsl_rx_frame_t;

    typedef struct packed {
        irsl_tx_kind_t kind;
        logic [7:0]    rate;
        logic [7:0]    turnaround;
        logic [7:0]    window;
        logic [7:0]    disc_wait;
    } irsl_tx_frame_t;

endpackage

// *** hdl/irsl_baud_gen.sv ***
// Fixed bit-rate tick generator for polling and negotiation
`timescale 1ns/1ps
module irsl_baud_gen
    import irsl_pkg::*;
#(
    parameter int unsigned DIV = BAUD_DIV
) (
    // Clock and reset
    input  wire logic CLK,
    input  wire logic SYS_RST,
    input  wire logic CE,
    // Tick out
    output logic      TICK
);

    logic [BAUD_W-1:0] cnt_reg;

    // One tick per bit period; the rate never changes since no faster rate is offered
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            cnt_reg <= '0;
        end else if (CE) begin
            if (cnt_reg == BAUD_W'(DIV - 1)) begin
                cnt_reg <= '0;
            end else begin
                cnt_reg <= cnt_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            TICK <= 1'b0;
        end else if (CE) begin
            TICK <= (cnt_reg == BAUD_W'(DIV - 1));
        end else begin
            TICK <= 1'b0;
        end
    end

endmodule

// *** hdl/irsl_link_setup.sv ***
// Secondary-station connection setup controller for the infrared link
`timescale 1ns/1ps
module irsl_link_setup
    import irsl_pkg::*;
#(
    parameter int unsigned BAUD_DIVIDE = BAUD_DIV
) (
    // Clock, reset, enable
    input  wire logic           CLK,
    input  wire logic           SYS_RST,
    input  wire logic           CE,
    // Frame receiver
    input  wire logic           RX_BUSY,
    input  wire logic           RX_VALID,
    input  wire irsl_rx_frame_t RX_FRAME,
    // Frame transmitter
    input  wire logic           TX_READY,
    output logic                TX_REQ,
    output irsl_tx_frame_t      TX_FRAME,
    // Host side
    input  wire logic           HOST_BUF_FULL,
    output logic                CTS_N,
    // Status and bit clock
    output irsl_state_t         LINK_STATE,
    output logic                BAUD_TICK
);

    // ****************************************
    // Declarations
    // ****************************************
    irsl_state_t    state_reg;
    logic           rsp_pend_reg;
    irsl_tx_frame_t tx_frame_reg;
    logic           tx_accept;
    logic           is_poll0;
    logic           is_bcast;

    // True when a response of the given kind is handed over at this edge
    function automatic logic sent_kind(input logic accept, input irsl_tx_frame_t frm, input irsl_tx_kind_t kind);
        return accept && (frm.kind == kind);
    endfunction

    // One fixed slot: as the only secondary on the link there is no contention logic
    // Only completed frames steer us; nothing here starts an exchange
    assign is_poll0  = RX_VALID && (RX_FRAME.kind == IRSL_RX_XID) && (RX_FRAME.slot == OWN_SLOT);
    assign is_bcast  = RX_VALID && (RX_FRAME.kind == IRSL_RX_BCAST);
    assign tx_accept = CE && TX_REQ && TX_READY;

    // ****************************************
    // Bit-rate generator
    // ****************************************
    irsl_baud_gen #(
        .DIV     (BAUD_DIVIDE)
    ) u_baud (
        .CLK     (CLK),
        .SYS_RST (SYS_RST),
        .CE      (CE),
        .TICK    (BAUD_TICK)
    );

    // ****************************************
    // Response scheduling
    // ****************************************
    // Any new frame cancels a stale response: once the next poll starts, slot zero has passed
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            rsp_pend_reg <= 1'b0;
            tx_frame_reg <= '0;
        end else if (CE) begin
            if (RX_VALID) begin
                if (is_poll0 && state_reg != IRSL_ST_CONN) begin
                    rsp_pend_reg      <= 1'b1;
                    tx_frame_reg      <= '0;
                    tx_frame_reg.kind <= IRSL_TX_XID_RSP;
                end else if (RX_FRAME.kind == IRSL_RX_SNRM && state_reg == IRSL_ST_DISCV) begin
                    rsp_pend_reg            <= 1'b1;
                    tx_frame_reg.kind       <= IRSL_TX_UA;
                    tx_frame_reg.rate       <= RATE_CODE_9600;
                    tx_frame_reg.turnaround <= TURNAROUND_CODE;
                    tx_frame_reg.window     <= WINDOW_CODE;
                    tx_frame_reg.disc_wait  <= DISC_WAIT_CODE;
                end else if (RX_FRAME.kind == IRSL_RX_DISC && state_reg == IRSL_ST_CONN) begin
                    rsp_pend_reg      <= 1'b1;
                    tx_frame_reg      <= '0;
                    tx_frame_reg.kind <= IRSL_TX_UA;
                end else begin
                    rsp_pend_reg <= 1'b0;
                end
            end else if (tx_accept) begin
                rsp_pend_reg <= 1'b0;
            end
        end
    end

    // Wait for the receiver to go quiet before asking to send
    assign TX_REQ   = CE && rsp_pend_reg && !RX_BUSY && !RX_VALID;
    assign TX_FRAME = tx_frame_reg;

    // ****************************************
    // Connection state
    // ****************************************
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            state_reg <= IRSL_ST_NDM;
        end else if (CE) begin
            case (state_reg)
                IRSL_ST_NDM: begin
                    if (sent_kind(tx_accept, tx_frame_reg, IRSL_TX_XID_RSP)) begin
                        state_reg <= IRSL_ST_CLAIM;
                    end
                end
                IRSL_ST_CLAIM: begin
                    // No timer: an unfinished round simply leaves us waiting here
                    if (is_bcast) begin
                        state_reg <= IRSL_ST_DISCV;
                    end
                end
                IRSL_ST_DISCV: begin
                    if (sent_kind(tx_accept, tx_frame_reg, IRSL_TX_UA)) begin
                        state_reg <= IRSL_ST_CONN;
                    end
                end
                IRSL_ST_CONN: begin
                    if (sent_kind(tx_accept, tx_frame_reg, IRSL_TX_UA)) begin
                        state_reg <= IRSL_ST_NDM;
                    end
                end
                default: begin
                    state_reg <= IRSL_ST_NDM;
                end
            endcase
        end
    end

    assign LINK_STATE = state_reg;

    // Host held off until connected, then paced by the receive buffer
    assign CTS_N = (state_reg == IRSL_ST_CONN) ? HOST_BUF_FULL : 1'b1;

    // ****************************************
    // Assertions
    // ****************************************
    property p_half_duplex;
        @(posedge CLK) disable iff (SYS_RST)
        RX_BUSY |-> !TX_REQ;
    endproperty
    a_half_duplex: assert property (p_half_duplex) else $error("Transmit requested while receiving");

    property p_poll0_answer;
        @(posedge CLK) disable iff (SYS_RST)
        CE && is_poll0 && state_reg != IRSL_ST_CONN |=> rsp_pend_reg && TX_FRAME.kind == IRSL_TX_XID_RSP;
    endproperty
    a_poll0_answer: assert property (p_poll0_answer) else $error("Poll zero not answered");

    property p_other_polls_silent;
        @(posedge CLK) disable iff (SYS_RST)
        CE && RX_VALID && !is_poll0 && state_reg inside {IRSL_ST_NDM, IRSL_ST_CLAIM} |=> !rsp_pend_reg;
    endproperty
    a_other_polls_silent: assert property (p_other_polls_silent) else $error("Answered a foreign slot");

    property p_only_on_request;
        @(posedge CLK) disable iff (SYS_RST)
        TX_REQ |-> $past(rsp_pend_reg) || $past(RX_VALID, 1);
    endproperty
    a_only_on_request: assert property (p_only_on_request) else $error("Unsolicited transmit");

    property p_cts_held;
        @(posedge CLK) disable iff (SYS_RST)
        state_reg != IRSL_ST_CONN |-> CTS_N;
    endproperty
    a_cts_held: assert property (p_cts_held) else $error("CTS active while not connected");

    property p_enter_discovery;
        @(posedge CLK) disable iff (SYS_RST)
        CE && state_reg == IRSL_ST_CLAIM && is_bcast |=> state_reg == IRSL_ST_DISCV;
    endproperty
    a_enter_discovery: assert property (p_enter_discovery) else $error("Discovery not entered");

    property p_no_early_discovery;
        @(posedge CLK) disable iff (SYS_RST)
        state_reg == IRSL_ST_DISCV && $past(state_reg) != IRSL_ST_DISCV |-> $past(state_reg) == IRSL_ST_CLAIM;
    endproperty
    a_no_early_discovery: assert property (p_no_early_discovery) else $error("Discovery skipped claim");

    property p_rate_reply;
        @(posedge CLK) disable iff (SYS_RST)
        TX_REQ && state_reg == IRSL_ST_DISCV && TX_FRAME.kind == IRSL_TX_UA |-> TX_FRAME.rate == RATE_CODE_9600;
    endproperty
    a_rate_reply: assert property (p_rate_reply) else $error("Wrong rate offered");

    property p_close_link;
        @(posedge CLK) disable iff (SYS_RST)
        CE && state_reg == IRSL_ST_CONN && RX_VALID && RX_FRAME.kind == IRSL_RX_DISC
        |=> rsp_pend_reg && TX_FRAME.kind == IRSL_TX_UA;
    endproperty
    a_close_link: assert property (p_close_link) else $error("Close link not confirmed");

    property p_flow;
        @(posedge CLK) disable iff (SYS_RST)
        state_reg == IRSL_ST_CONN |-> CTS_N == HOST_BUF_FULL;
    endproperty
    a_flow: assert property (p_flow) else $error("CTS does not follow buffer full");

    property p_reset_state;
        @(posedge CLK) disable iff (SYS_RST)
        $past(SYS_RST) |-> state_reg == IRSL_ST_NDM && !rsp_pend_reg;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("Not disconnected after reset");

    property p_baud_gap;
        @(posedge CLK) disable iff (SYS_RST)
        BAUD_TICK |=> !BAUD_TICK [*8];
    endproperty
    a_baud_gap: assert property (p_baud_gap) else $error("Bit ticks too close");

    property p_claim_on_response;
        @(posedge CLK) disable iff (SYS_RST)
        state_reg == IRSL_ST_NDM && sent_kind(tx_accept, TX_FRAME, IRSL_TX_XID_RSP) |=> state_reg == IRSL_ST_CLAIM;
    endproperty
    a_claim_on_response: assert property (p_claim_on_response) else $error("Claim not kept after poll reply");

    property p_claim_needs_answer;
        @(posedge CLK) disable iff (SYS_RST)
        state_reg == IRSL_ST_CLAIM && $past(state_reg) == IRSL_ST_NDM |-> $past(tx_accept);
    endproperty
    a_claim_needs_answer: assert property (p_claim_needs_answer) else $error("Claim without a sent reply");

    property p_connect_on_ua;
        @(posedge CLK) disable iff (SYS_RST)
        state_reg == IRSL_ST_DISCV && sent_kind(tx_accept, TX_FRAME, IRSL_TX_UA) |=> state_reg == IRSL_ST_CONN;
    endproperty
    a_connect_on_ua: assert property (p_connect_on_ua) else $error("Not connected after parameter reply");

    property p_conn_needs_discovery;
        @(posedge CLK) disable iff (SYS_RST)
        state_reg == IRSL_ST_CONN && $past(state_reg) != IRSL_ST_CONN |-> $past(state_reg) == IRSL_ST_DISCV;
    endproperty
    a_conn_needs_discovery: assert property (p_conn_needs_discovery) else $error("Connected without discovery");

    property p_close_return;
        @(posedge CLK) disable iff (SYS_RST)
        state_reg == IRSL_ST_CONN && sent_kind(tx_accept, TX_FRAME, IRSL_TX_UA) |=> state_reg == IRSL_ST_NDM;
    endproperty
    a_close_return: assert property (p_close_return) else $error("Not disconnected after close");

    property p_conn_polls_ignored;
        @(posedge CLK) disable iff (SYS_RST)
        CE && state_reg == IRSL_ST_CONN && is_poll0 |=> !rsp_pend_reg;
    endproperty
    a_conn_polls_ignored: assert property (p_conn_polls_ignored) else $error("Poll answered while connected");

    property p_req_holds;
        @(posedge CLK) disable iff (SYS_RST)
        TX_REQ && !TX_READY |=> rsp_pend_reg && $stable(TX_FRAME);
    endproperty
    a_req_holds: assert property (p_req_holds) else $error("Pending reply dropped or changed");

    property p_one_reply;
        @(posedge CLK) disable iff (SYS_RST)
        tx_accept |=> !TX_REQ;
    endproperty
    a_one_reply: assert property (p_one_reply) else $error("Reply requested twice");

    property p_ua_params;
        @(posedge CLK) disable iff (SYS_RST)
        TX_REQ && state_reg == IRSL_ST_DISCV && TX_FRAME.kind == IRSL_TX_UA |-> TX_FRAME.turnaround == TURNAROUND_CODE
        && TX_FRAME.window == WINDOW_CODE && TX_FRAME.disc_wait == DISC_WAIT_CODE;
    endproperty
    a_ua_params: assert property (p_ua_params) else $error("Wrong link parameters offered");

    property p_idle_when_frozen;
        @(posedge CLK) disable iff (SYS_RST)
        !CE |-> !TX_REQ;
    endproperty
    a_idle_when_frozen: assert property (p_idle_when_frozen) else $error("Transmit requested while frozen");

    property p_frozen;
        @(posedge CLK) disable iff (SYS_RST)
        !CE |=> $stable(state_reg) && $stable(rsp_pend_reg) && $stable(TX_FRAME);
    endproperty
    a_frozen: assert property (p_frozen) else $error("State moved while frozen");

    c_poll_reply: cover property (@(posedge CLK) disable iff (SYS_RST) sent_kind(tx_accept, TX_FRAME, IRSL_TX_XID_RSP));
    c_claim:    cover property (@(posedge CLK) disable iff (SYS_RST) state_reg == IRSL_ST_CLAIM);
    c_discover: cover property (@(posedge CLK) disable iff (SYS_RST) state_reg == IRSL_ST_DISCV);
    c_connect:  cover property (@(posedge CLK) disable iff (SYS_RST) state_reg == IRSL_ST_CONN);
    c_close:    cover property (@(posedge CLK) disable iff (SYS_RST)
                                state_reg == IRSL_ST_CONN ##1 state_reg == IRSL_ST_NDM);

endmodule

// *** tb/irsl_primary_model.sv ***
// Behavioural remote primary station: frame source and response sink
`timescale 1ns/1ps
module irsl_primary_model
    import irsl_pkg::*;
(
    // Clock and enable seen by the transmitter
    input  wire logic            CLK,
    input  wire logic            CE,
    // Responses from the block
    input  wire logic            TX_REQ,
    input  wire irsl_tx_frame_t  TX_FRAME,
    // Frames towards the block
    output logic                 RX_BUSY,
    output logic                 RX_VALID,
    output irsl_rx_frame_t       RX_FRAME,
    output logic                 TX_READY
);
    int             ready_delay = 0;
    int             wait_cnt    = 0;
    int             tx_count    = 0;
    int             dup_err     = 0;
    irsl_tx_frame_t last_tx     = '0;

    initial begin
        RX_BUSY  = 1'b0;
        RX_VALID = 1'b0;
        RX_FRAME = '0;
        TX_READY = 1'b0;
    end

    // ****************************************
    // Frame source, one whole frame per call, three clocks busy then one clock valid
    // ****************************************
    task automatic send(input irsl_rx_kind_t kind, input logic [7:0] slot, input int tail);
        @(negedge CLK);
        RX_BUSY  = 1'b1;
        repeat (3) @(negedge CLK);
        RX_BUSY  = 1'b0;
        RX_VALID = 1'b1;
        RX_FRAME = '{kind: kind, slot: slot};
        @(negedge CLK);
        RX_VALID = 1'b0;
        // Stale frame content must not be trusted between frames
        RX_FRAME = irsl_rx_frame_t'(~RX_FRAME);
        // A tail models the next frame starting at once, as on a point-to-point link
        RX_BUSY  = (tail > 0);
        repeat (tail) @(negedge CLK);
        RX_BUSY  = 1'b0;
    endtask

    // ****************************************
    // Response sink; settles after the bench's own falling-edge writes
    // ****************************************
    always @(negedge CLK) begin
        #1;
        if (TX_REQ && RX_BUSY) dup_err++;
        if (!TX_REQ) begin
            TX_READY = 1'b0;
            wait_cnt = 0;
        end else if (wait_cnt >= ready_delay) begin
            TX_READY = 1'b1;
        end else begin
            wait_cnt++;
        end
        // Counted here; taken by the block at the coming rising edge
        if (CE && TX_REQ && TX_READY) begin
            tx_count++;
            last_tx = TX_FRAME;
        end
    end
endmodule

// *** tb/irsl_link_setup_tb.sv ***
// Self-checking bench for the secondary link setup controller
`timescale 1ns/1ps
module irsl_link_setup_tb;
    import irsl_pkg::*;
    logic           clk = 1'b0;
    logic           sys_rst = 1'b1;
    logic           ce = 1'b1;
    logic           host_buf_full = 1'b0;
    logic           rx_busy, rx_valid, tx_ready, tx_req, cts_n, baud_tick;
    irsl_rx_frame_t rx_frame;
    irsl_tx_frame_t tx_frame;
    irsl_state_t    link_state;
    int             n_fail = 0;
    int             num_checks = 0;
    int             cyc = 0;

    always #10 clk = ~clk;

    irsl_link_setup #(.BAUD_DIVIDE(16)) i_dut (.CLK(clk), .SYS_RST(sys_rst), .CE(ce), .RX_BUSY(rx_busy),
        .RX_VALID(rx_valid), .RX_FRAME(rx_frame), .TX_READY(tx_ready), .TX_REQ(tx_req), .TX_FRAME(tx_frame),
        .HOST_BUF_FULL(host_buf_full), .CTS_N(cts_n), .LINK_STATE(link_state), .BAUD_TICK(baud_tick));
    irsl_primary_model i_pri (.CLK(clk), .CE(ce), .TX_REQ(tx_req), .TX_FRAME(tx_frame), .RX_BUSY(rx_busy),
        .RX_VALID(rx_valid), .RX_FRAME(rx_frame), .TX_READY(tx_ready));

    // ****************************************
    // Helpers
    // ****************************************
    task automatic chk(input bit ok, input string msg);
        num_checks++;
        if (!ok) begin
            n_fail++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask

    task automatic expect_tx(input irsl_tx_kind_t kind);
        int base;
        base = i_pri.tx_count;
        for (int i = 0; i < 40 && i_pri.tx_count == base; i++) @(posedge clk);
        #1;
        chk(i_pri.tx_count == base + 1, "response missing");
        chk(i_pri.last_tx.kind === kind, "response kind");
    endtask

    task automatic expect_none(input irsl_state_t st);
        int base;
        base = i_pri.tx_count;
        repeat (20) @(posedge clk);
        #1;
        chk(i_pri.tx_count == base, "unexpected response");
        chk(link_state === st, "link state");
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        chk(link_state === IRSL_ST_NDM && tx_req === 1'b0, "reset state");
        chk(cts_n === 1'b1, "cts while disconnected");
    endtask

    task automatic t_refuse_ndm();
        i_pri.send(IRSL_RX_SNRM, 8'h00, 0);
        expect_none(IRSL_ST_NDM);
        i_pri.send(IRSL_RX_DISC, 8'h00, 0);
        expect_none(IRSL_ST_NDM);
        i_pri.send(IRSL_RX_XID, 8'h01, 0);
        expect_none(IRSL_ST_NDM);
        i_pri.send(IRSL_RX_BCAST, 8'h00, 0);
        expect_none(IRSL_ST_NDM);
        @(negedge clk);
        ce = 1'b0;
        i_pri.send(IRSL_RX_XID, 8'h00, 0);
        ce = 1'b1;
        expect_none(IRSL_ST_NDM);
    endtask

    task automatic t_incomplete();
        int base;
        base = i_pri.tx_count;
        i_pri.send(IRSL_RX_XID, 8'h00, 6);
        chk(i_pri.tx_count == base, "sent while receiving");
        expect_tx(IRSL_TX_XID_RSP);
        chk(i_pri.dup_err == 0, "talked over a frame");
        repeat (300) @(posedge clk);
        #1;
        chk(link_state === IRSL_ST_CLAIM && cts_n === 1'b1, "left disconnected alone");
    endtask

    task automatic t_poll_round();
        i_pri.ready_delay = 5;
        i_pri.send(IRSL_RX_XID, 8'h00, 0);
        expect_tx(IRSL_TX_XID_RSP);
        for (int s = 1; s < 8; s++) begin
            i_pri.send(IRSL_RX_XID, s[7:0], 0);
            expect_none(IRSL_ST_CLAIM);
        end
        i_pri.send(IRSL_RX_BCAST, 8'h00, 0);
        expect_none(IRSL_ST_DISCV);
        chk(cts_n === 1'b1, "cts during discovery");
        i_pri.ready_delay = 0;
        i_pri.send(IRSL_RX_XID, 8'h00, 0);
        expect_tx(IRSL_TX_XID_RSP);
        i_pri.send(IRSL_RX_DISC, 8'h00, 0);
        expect_none(IRSL_ST_DISCV);
    endtask

    task automatic t_connect();
        i_pri.send(IRSL_RX_SNRM, 8'h00, 0);
        expect_tx(IRSL_TX_UA);
        chk(i_pri.last_tx.rate === RATE_CODE_9600, "rate byte");
        chk(i_pri.last_tx.turnaround === TURNAROUND_CODE && i_pri.last_tx.window === WINDOW_CODE, "params");
        chk(i_pri.last_tx.disc_wait === DISC_WAIT_CODE, "wait byte");
        chk(link_state === IRSL_ST_CONN && cts_n === 1'b0, "connected, room");
        @(negedge clk);
        host_buf_full = 1'b1;
        #1;
        chk(cts_n === 1'b1, "host held off when full");
        @(negedge clk);
        host_buf_full = 1'b0;
        i_pri.send(IRSL_RX_XID, 8'h00, 0);
        expect_none(IRSL_ST_CONN);
    endtask

    task automatic t_mid_reset();
        i_pri.send(IRSL_RX_XID, 8'h00, 0);
        expect_tx(IRSL_TX_XID_RSP);
        chk(link_state === IRSL_ST_CLAIM, "claim before reset");
        @(negedge clk);
        sys_rst = 1'b1;
        repeat (2) @(negedge clk);
        sys_rst = 1'b0;
        chk(link_state === IRSL_ST_NDM && cts_n === 1'b1 && tx_req === 1'b0, "mid-run reset");
    endtask

    task automatic t_close();
        i_pri.send(IRSL_RX_DISC, 8'h00, 0);
        expect_tx(IRSL_TX_UA);
        chk(i_pri.last_tx.rate === 8'h00 && link_state === IRSL_ST_NDM && cts_n === 1'b1, "closed");
    endtask

    task automatic t_baud();
        int n;
        n = 0;
        @(posedge baud_tick);
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (baud_tick !== 1'b1 && n < 100);
        chk(n == 16, "bit tick spacing");
    endtask

    // ****************************************
    // Main sequence and hang guard
    // ****************************************
    always @(posedge clk) begin
        cyc++;
        if (cyc == 6000) begin
            n_fail++;
            tally_and_finish();
        end
    end

    initial begin
        repeat (12) @(negedge clk);
        sys_rst = 1'b0;
        t_reset();
        t_refuse_ndm();
        t_incomplete();
        t_poll_round();
        t_connect();
        t_close();
        t_mid_reset();
        t_baud();
        tally_and_finish();
    end
endmodule
